// file: verilog/tssfc_pkg.sv
// What this block does
// - Two-speed start-up runs from internal RC first
// - Every reset forces clock select to primary
// - Every reset zeroes internal frequency select
// - Two-speed start-up only for crystal modes
// - Non-zero frequency select uses fast oscillator
// - Clock select writable before start-up timeout
// - Sleep aborts start-up, running bit clear
// - Count 1024 primary cycles, await RC fall
// - Hold clock eight falls, then switch over
// - Monitor works only when enabled
// - Failure raises flag, switches to internal
// - Fail-safe ends by reset, sleep, write
// - Fail-safe frequency follows frequency select
// - Sample clock is internal RC over 64
// - Latch cleared rising, set sysclk falling
// - Reset in fail-safe, crystal waits timer
// - Monitor enable also enables two-speed start-up
// - Reset in fail-safe, external source immediately
// - After fail-safe, follow select, keep monitoring
// - Failure forces select to internal, clears watchdog
// - No failure detection during start-up timer
// - Non-crystal primaries are monitored immediately
// - Software clock switch releases watchdog counter
// - Watchdog held in reset while timer counts
//
// Purpose: Constants for the start-up and clock monitor block, plus the
//          pin edge sampler that the main module uses.
// Assumes: Oscillator pins are far slower than i_clk.
// Notes:   Register offsets are word indices on the plain register port.
package tssfc_pkg;
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [1:0] REG_OSC_CTRL = 2'h0;
  localparam logic [1:0] REG_FAIL_STAT = 2'h1;
  // Control register fields.
  localparam int SCS_LSB = 0;
  localparam int INTERNAL_OSC_STABLE_BIT = 2;
  localparam int PRIMARY_CLOCK_RUNNING_BIT = 3;
  localparam int INTERNAL_FREQ_SELECT_LSB = 4;
  // Status register fields; writing one to the flag bit clears it.
  localparam int FLAG_BIT = 0;
  localparam int FAILSAFE_BIT = 1;
  localparam logic [1:0] SCS_PRIMARY = 2'h0;
  localparam logic [1:0] SCS_SECONDARY = 2'h1;
  localparam logic [1:0] SCS_INTERNAL = 2'h2;
  localparam logic [2:0] INTERNAL_FREQ_SELECT_RESET = 3'h0;
  // Primary oscillator configuration codes.
  localparam logic [2:0] FOSC_LP = 3'h0;
  localparam logic [2:0] FOSC_XT = 3'h1;
  localparam logic [2:0] FOSC_HS = 3'h2;
  localparam logic [2:0] FOSC_EC = 3'h3;
  localparam logic [2:0] FOSC_ERC = 3'h4;
  localparam logic [2:0] FOSC_INTERNAL_RC_LOWFREQ = 3'h5;
  // Clock source selection driven out to the clock multiplexer.
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_PRIMARY = 3'h1;
  localparam logic [2:0] SRC_SECONDARY = 3'h2;
  localparam logic [2:0] SRC_LOWFREQ = 3'h3;
  localparam logic [2:0] SRC_HIGHFREQ = 3'h4;
  localparam int OST_CYCLES = 1024;
  localparam int HOLD_FALLS = 8;
  localparam int SAMPLE_DIV = 64;
endpackage : tssfc_pkg

`timescale 1ns/1ps
// Purpose: Brings one oscillator pin into i_clk and marks its edges.
// Assumes: The pin holds each level for at least two i_clk cycles.
// Notes:   Edges are detected after the two-flop synchroniser only.
module tssfc_edge (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_pin,
  output logic o_rise,
  output logic o_fall
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else if (i_ce) begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign o_rise = i_ce && sync_q && !last_q;
  assign o_fall = i_ce && !sync_q && last_q;
endmodule : tssfc_edge

// file: verilog/tssfc_top.sv
// Purpose: Two-speed start-up sequencer and fail-safe clock monitor.
// Assumes: Oscillators arrive as slow pins; configuration is static.
// Notes:   The block selects clock sources; the glitch-free mux is outside.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module tssfc_top #(
  parameter int OST_COUNT = tssfc_pkg::OST_CYCLES,
  parameter int HOLD_COUNT = tssfc_pkg::HOLD_FALLS,
  parameter int SAMPLE_COUNT = tssfc_pkg::SAMPLE_DIV
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic [tssfc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [tssfc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  output logic [tssfc_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_two_speed_enable_cfg,
  input wire logic i_clock_monitor_enable_cfg,
  input wire logic [2:0] i_fosc_mode,
  input wire logic i_power_up_timer_enable_n,
  input wire logic i_power_up_done,
  input wire logic i_sleep,
  input wire logic i_wake,
  input wire logic i_watchdog_enable,
  input wire logic i_primary_osc,
  input wire logic i_secondary_timer_osc,
  input wire logic i_internal_rc_lowfreq,
  input wire logic i_internal_osc_stable,
  output logic [2:0] o_clk_src,
  output logic o_sysclk_hold_low,
  output logic o_watchdog_hold,
  output logic o_watchdog_clear,
  output logic o_osc_fail_flag
);
  import tssfc_pkg::*;

  typedef enum {
    ST_BOOT, ST_OST, ST_WAIT_FALL, ST_HOLD, ST_PRIMARY, ST_ALT,
    ST_SLEEP, ST_FAILSAFE
  } tssfc_state_t;

  logic rst_meta_q;
  logic rst_n;
  tssfc_state_t state_q;
  tssfc_state_t state_d;
  logic [1:0] scs_q;
  logic [1:0] scs_d;
  logic [2:0] internal_freq_select_q;
  logic primary_clock_running_q;
  logic primary_clock_running_d;
  logic flag_q;
  logic latch_q;
  logic [9:0] ost_cnt_q;
  logic [3:0] hold_cnt_q;
  logic [5:0] div_q;
  logic [DATA_W-1:0] rdata_q;
  logic stable_meta_q;
  logic stable_q;
  logic wdclr_q;
  logic pri_rise;
  logic pri_fall;
  logic sec_fall;
  logic rc_fall;

  // Reset release is synchronised; assertion stays asynchronous.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  tssfc_edge u_pri (
    .i_clk(i_clk), .i_rst_n(rst_n), .i_ce(i_ce), .i_pin(i_primary_osc),
    .o_rise(pri_rise), .o_fall(pri_fall)
  );
  tssfc_edge u_sec (
    .i_clk(i_clk), .i_rst_n(rst_n), .i_ce(i_ce),
    .i_pin(i_secondary_timer_osc), .o_rise(), .o_fall(sec_fall)
  );
  tssfc_edge u_rc (
    .i_clk(i_clk), .i_rst_n(rst_n), .i_ce(i_ce),
    .i_pin(i_internal_rc_lowfreq), .o_rise(), .o_fall(rc_fall)
  );

  function automatic logic is_crystal(input logic [2:0] mode);
    is_crystal = (mode == FOSC_LP) || (mode == FOSC_XT) ||
                 (mode == FOSC_HS);
  endfunction : is_crystal

  // Bus decode.
  wire wr_ctrl = i_ce && i_we && (i_addr == REG_OSC_CTRL);
  wire wr_stat = i_ce && i_we && (i_addr == REG_FAIL_STAT);
  wire flag_clr = wr_stat && i_wdata[FLAG_BIT];
  wire [1:0] wr_scs = i_wdata[SCS_LSB+1:SCS_LSB];

  wire crystal = is_crystal(i_fosc_mode);
  wire two_speed = i_two_speed_enable_cfg || i_clock_monitor_enable_cfg;
  wire pwrt_ok = i_power_up_timer_enable_n || i_power_up_done;
  wire starting = (state_q == ST_OST) || (state_q == ST_WAIT_FALL) ||
                  (state_q == ST_HOLD);
  wire ost_done = pri_rise && (ost_cnt_q == 10'(OST_COUNT - 1));
  wire hold_done = pri_fall && (hold_cnt_q == 4'(HOLD_COUNT - 1));

  // Sample clock: internal RC falls divided down; high in the upper half.
  wire [5:0] div_next = (div_q == 6'(SAMPLE_COUNT - 1)) ? 6'h0 : div_q + 6'h1;
  wire samp_rise = rc_fall && (div_next == 6'(SAMPLE_COUNT / 2));
  wire samp_fall = rc_fall && (div_next == 6'h0);

  // Only a running primary or secondary clock is watched; the start-up
  // window is excluded so a slow crystal is never called a failure.
  wire mon_pri = (state_q == ST_PRIMARY);
  wire mon_sec = (state_q == ST_ALT) && (scs_q == SCS_SECONDARY);
  wire mon_on = i_clock_monitor_enable_cfg && (mon_pri || mon_sec);
  wire sys_fall = (mon_pri && pri_fall) || (mon_sec && sec_fall);
  wire fail_det = mon_on && samp_fall && !latch_q;

  // Entry to a start sequence after reset or wake.
  function automatic tssfc_state_t start_state(input logic xtal);
    start_state = xtal ? ST_OST : ST_PRIMARY;
  endfunction : start_state

  always_comb begin
    state_d = state_q;
    scs_d = scs_q;
    primary_clock_running_d = primary_clock_running_q;
    case (state_q)
      ST_BOOT: begin
        if (pwrt_ok) begin
          state_d = start_state(crystal);
          primary_clock_running_d = !crystal;
        end
      end
      ST_OST, ST_WAIT_FALL, ST_HOLD: begin
        if (i_sleep) begin
          state_d = ST_SLEEP;
          primary_clock_running_d = 1'b0;
        end else if (wr_ctrl && wr_scs != SCS_PRIMARY) begin
          state_d = ST_ALT;
          scs_d = wr_scs;
        end else if (state_q == ST_OST && ost_done) begin
          state_d = ST_WAIT_FALL;
        end else if (state_q == ST_WAIT_FALL && rc_fall) begin
          state_d = ST_HOLD;
          primary_clock_running_d = 1'b1;
        end else if (state_q == ST_HOLD && hold_done) begin
          state_d = ST_PRIMARY;
        end
      end
      ST_PRIMARY, ST_ALT, ST_FAILSAFE: begin
        if (fail_det) begin
          state_d = ST_FAILSAFE;
          scs_d = SCS_INTERNAL;
          primary_clock_running_d = 1'b0;
        end else if (i_sleep) begin
          state_d = ST_SLEEP;
          primary_clock_running_d = 1'b0;
        end else if (wr_ctrl) begin
          scs_d = wr_scs;
          if (wr_scs != SCS_PRIMARY) begin
            state_d = ST_ALT;
          end else if (state_q != ST_PRIMARY) begin
            state_d = start_state(crystal);
            primary_clock_running_d = !crystal;
          end
        end
      end
      ST_SLEEP: begin
        if (i_wake) begin
          if (scs_q != SCS_PRIMARY) begin
            state_d = ST_ALT;
          end else begin
            state_d = start_state(crystal);
            primary_clock_running_d = !crystal;
          end
        end
      end
      default: state_d = ST_BOOT;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_BOOT;
      scs_q <= SCS_PRIMARY;
      internal_freq_select_q <= INTERNAL_FREQ_SELECT_RESET;
      primary_clock_running_q <= 1'b0;
    end else if (i_ce) begin
      state_q <= state_d;
      scs_q <= scs_d;
      primary_clock_running_q <= primary_clock_running_d;
      if (wr_ctrl) begin
        internal_freq_select_q <= i_wdata[INTERNAL_FREQ_SELECT_LSB+2:INTERNAL_FREQ_SELECT_LSB];
      end
    end
  end

  // Start-up timer and the hold-low counter of primary falls.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ost_cnt_q <= 10'h0;
      hold_cnt_q <= 4'h0;
    end else if (i_ce) begin
      if (state_q != ST_OST) begin
        ost_cnt_q <= 10'h0;
      end else if (pri_rise) begin
        ost_cnt_q <= ost_cnt_q + 10'h1;
      end
      if (state_q != ST_HOLD) begin
        hold_cnt_q <= 4'h0;
      end else if (pri_fall) begin
        hold_cnt_q <= hold_cnt_q + 4'h1;
      end
    end
  end

  // Monitor latch: the system clock fall wins over the sample rise.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 6'h0;
      latch_q <= 1'b0;
      flag_q <= 1'b0;
      wdclr_q <= 1'b0;
    end else if (i_ce) begin
      if (rc_fall) begin
        div_q <= div_next;
      end
      if (sys_fall) begin
        latch_q <= 1'b1;
      end else if (samp_rise) begin
        latch_q <= 1'b0;
      end
      if (fail_det) begin
        flag_q <= 1'b1;
      end else if (flag_clr) begin
        flag_q <= 1'b0;
      end
      wdclr_q <= fail_det && i_watchdog_enable;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      stable_meta_q <= 1'b0;
      stable_q <= 1'b0;
      rdata_q <= '0;
    end else if (i_ce) begin
      stable_meta_q <= i_internal_osc_stable;
      stable_q <= stable_meta_q;
      if (i_re && i_addr == REG_OSC_CTRL) begin
        rdata_q <= {1'b0, internal_freq_select_q, primary_clock_running_q, stable_q && (internal_freq_select_q != 3'h0),
                    scs_q};
      end else if (i_re && i_addr == REG_FAIL_STAT) begin
        rdata_q <= {6'h0, state_q == ST_FAILSAFE, flag_q};
      end else begin
        rdata_q <= '0;
      end
    end
  end

  // Internal source runs fast or slow as the frequency field asks.
  wire [2:0] int_src = (internal_freq_select_q != 3'h0) ? SRC_HIGHFREQ : SRC_LOWFREQ;
  always_comb begin
    case (state_q)
      ST_OST, ST_WAIT_FALL, ST_HOLD: o_clk_src = two_speed ? int_src
                                                           : SRC_NONE;
      ST_PRIMARY: o_clk_src = SRC_PRIMARY;
      ST_ALT: o_clk_src = (scs_q == SCS_SECONDARY) ? SRC_SECONDARY
                                                   : int_src;
      ST_FAILSAFE: o_clk_src = int_src;
      default: o_clk_src = SRC_NONE;
    endcase
  end

  assign o_rdata = rdata_q;
  assign o_sysclk_hold_low = (state_q == ST_HOLD);
  assign o_watchdog_hold = starting;
  assign o_watchdog_clear = wdclr_q;
  assign o_osc_fail_flag = flag_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_fail;
    i_ce && fail_det;
  endsequence
  sequence seq_failsafe_entered;
    state_q == ST_FAILSAFE && scs_q == SCS_INTERNAL && flag_q;
  endsequence

  AST_RESET_FIELDS: assert property ($rose(rst_n) |->
    scs_q == SCS_PRIMARY && internal_freq_select_q == 3'h0)
    else $error("Select fields not cleared by reset.");
  AST_CRYSTAL_ONLY: assert property (state_q == ST_OST |-> crystal)
    else $error("Start-up timer runs for a non-crystal primary.");
  AST_SLEEP_ABORT: assert property (i_ce && starting && i_sleep |=>
    state_q == ST_SLEEP && !primary_clock_running_q)
    else $error("Sleep did not abort start-up.");
  AST_FAIL_RESPONSE: assert property (seq_fail |=>
    seq_failsafe_entered ##0 o_clk_src == int_src)
    else $error("Failure did not force internal clock.");
  AST_MON_DISABLED: assert property (!i_clock_monitor_enable_cfg &&
    !flag_q |=> !flag_q)
    else $error("Monitor reported failure while disabled.");
  AST_NO_FAIL_START: assert property (starting && !flag_q |=> !flag_q)
    else $error("Failure detected during start-up timer.");
  AST_HOLD_EXIT: assert property (i_ce && state_q == ST_HOLD &&
    pri_fall && hold_cnt_q == 4'(HOLD_COUNT - 1) && !i_sleep && !wr_ctrl
    |=> state_q == ST_PRIMARY && primary_clock_running_q && !o_sysclk_hold_low)
    else $error("Hold did not end after eight primary falls.");
  AST_OST_WDT: assert property (state_q == ST_OST |->
    o_watchdog_hold && o_clk_src != SRC_PRIMARY)
    else $error("Watchdog not held during start-up timer.");
  AST_FLAG_STICKY: assert property (flag_q && !(i_ce && flag_clr) |=>
    flag_q)
    else $error("Fail flag dropped without a clear.");
  AST_WDT_CLEAR: assert property (seq_fail and i_watchdog_enable |=>
    o_watchdog_clear)
    else $error("Watchdog not cleared on clock failure.");
endmodule : tssfc_top

// file: verification/tb_two_speed_startup_fail_safe_clock.sv
// Purpose: Self-checking bench for the start-up sequencer and clock monitor.
// Assumes: Oscillator pins are driven slowly, eight i_clk cycles per level.
// Notes:   Start-up and sample counts are shortened through parameters.
`timescale 1ns/1ps
module tb_two_speed_startup_fail_safe_clock;
  import tssfc_pkg::*;
  localparam int OST_N = 8;
  localparam int SMP_N = 8;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [7:0] rdata;
  logic ts_cfg = 1'b0;
  logic mon_cfg = 1'b0;
  logic [2:0] fosc = 3'h1;
  logic slp = 1'b0;
  logic wake = 1'b0;
  logic prim = 1'b0;
  logic rc = 1'b0;
  logic internal_osc_stable = 1'b0;
  logic ce = 1'b1;
  logic pwrt_n = 1'b1;
  logic pwr_done = 1'b0;
  logic wd_en = 1'b1;
  logic sec = 1'b0;
  logic [2:0] src;
  logic hold_low;
  logic wd_hold;
  logic wd_clr;
  logic flag;
  logic [7:0] v;
  logic [2:0] r;
  int n_errors = 0;
  int checked = 0;
  int n_wdclr = 0;
  int cycles = 0;

  tssfc_top #(
    .OST_COUNT(OST_N),
    .HOLD_COUNT(HOLD_FALLS),
    .SAMPLE_COUNT(SMP_N)
  ) i_dut (
    .i_clk(clk),
    .i_resetn(resetn),
    .i_ce(ce),
    .i_addr(addr),
    .i_wdata(wdata),
    .i_we(we),
    .i_re(re),
    .o_rdata(rdata),
    .i_two_speed_enable_cfg(ts_cfg),
    .i_clock_monitor_enable_cfg(mon_cfg),
    .i_fosc_mode(fosc),
    .i_power_up_timer_enable_n(pwrt_n),
    .i_power_up_done(pwr_done),
    .i_sleep(slp),
    .i_wake(wake),
    .i_watchdog_enable(wd_en),
    .i_primary_osc(prim),
    .i_secondary_timer_osc(sec),
    .i_internal_rc_lowfreq(rc),
    .i_internal_osc_stable(internal_osc_stable),
    .o_clk_src(src),
    .o_sysclk_hold_low(hold_low),
    .o_watchdog_hold(wd_hold),
    .o_watchdog_clear(wd_clr),
    .o_osc_fail_flag(flag)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  // The clear output is a one-cycle pulse, so it is counted on every edge.
  always @(posedge clk) begin
    if (wd_clr === 1'b1) begin
      n_wdclr++;
    end
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [1:0] a);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    v = rdata;
  endtask : rd

  // One step gives one internal RC fall if q is set and one primary fall if p is set, apart.
  task automatic step(input int n, input logic p, input logic q);
    repeat (n) begin
      rc <= q;
      cyc(4);
      prim <= p;
      sec <= p;
      cyc(4);
      rc <= 1'b0;
      cyc(4);
      prim <= 1'b0;
      sec <= 1'b0;
      cyc(4);
    end
  endtask : step

  task automatic pulse(input logic s);
    @(posedge clk);
    slp <= s;
    wake <= !s;
    @(posedge clk);
    slp <= 1'b0;
    wake <= 1'b0;
    cyc(2);
  endtask : pulse

  task automatic do_reset(input logic [2:0] m, input logic t, input logic c);
    @(posedge clk);
    resetn <= 1'b0;
    fosc <= m;
    ts_cfg <= t;
    mon_cfg <= c;
    cyc(6);
    resetn <= 1'b1;
    cyc(6);
  endtask : do_reset

  initial begin
    void'($urandom(87));
    do_reset(FOSC_XT, 1'b0, 1'b1);
    chk({5'h0, src}, {5'h0, SRC_LOWFREQ});
    chk({7'h0, wd_hold}, 8'h01);
    rd(REG_OSC_CTRL);
    chk(v, 8'h00);
    step(2 * SMP_N, 1'b0, 1'b1);
    chk({7'h0, flag}, 8'h00);
    step(OST_N, 1'b1, 1'b0);
    step(1, 1'b0, 1'b1);
    rd(REG_OSC_CTRL);
    chk(v, 8'h08);
    chk({7'h0, hold_low}, 8'h01);
    step(HOLD_FALLS, 1'b1, 1'b0);
    chk({5'h0, src}, {5'h0, SRC_PRIMARY});
    chk({6'h0, hold_low, wd_hold}, 8'h00);
    step(2 * SMP_N, 1'b1, 1'b1);
    chk({7'h0, flag}, 8'h00);
    step(2 * SMP_N, 1'b0, 1'b1);
    chk({7'h0, flag}, 8'h01);
    chk({5'h0, src}, {5'h0, SRC_LOWFREQ});
    chk(n_wdclr[7:0], 8'h01);
    rd(REG_OSC_CTRL);
    chk({6'h0, v[1:0]}, {6'h0, SCS_INTERNAL});
    rd(REG_FAIL_STAT);
    chk(v, 8'h03);
    // With the clock enable low the clear strobe must be ignored.
    ce <= 1'b0;
    wr(REG_FAIL_STAT, 8'h01);
    ce <= 1'b1;
    rd(REG_FAIL_STAT);
    chk(v, 8'h03);
    wr(REG_FAIL_STAT, 8'h01);
    rd(REG_FAIL_STAT);
    chk(v, 8'h02);
    r = 3'($urandom_range(7, 1));
    wr(REG_OSC_CTRL, {1'b0, r, 4'h2});
    chk({5'h0, src}, {5'h0, SRC_HIGHFREQ});
    rd(REG_FAIL_STAT);
    chk(v, 8'h00);
    rd(REG_OSC_CTRL);
    chk(v & 8'hf7, {1'b0, r, 4'h2});
    internal_osc_stable <= 1'b1;
    cyc(6);
    rd(REG_OSC_CTRL);
    chk(v & 8'hf7, {1'b0, r, 4'h6});
    wr(REG_OSC_CTRL, {1'b0, r, 4'h1});
    chk({5'h0, src}, {5'h0, SRC_SECONDARY});
    step(2 * SMP_N, 1'b1, 1'b1);
    chk({7'h0, flag}, 8'h00);
    step(2 * SMP_N, 1'b0, 1'b1);
    chk({5'h0, src}, {5'h0, SRC_HIGHFREQ});
    chk({7'h0, flag}, 8'h01);
    chk(n_wdclr[7:0], 8'h02);
    // A fresh crystal start with the stale fail condition still flagged.
    wr(REG_OSC_CTRL, 8'h00);
    chk({5'h0, src}, {5'h0, SRC_LOWFREQ});
    chk({7'h0, wd_hold}, 8'h01);
    step(2, 1'b1, 1'b0);
    wr(REG_OSC_CTRL, 8'h01);
    chk({5'h0, src}, {5'h0, SRC_SECONDARY});
    chk({7'h0, wd_hold}, 8'h00);
    wr(REG_OSC_CTRL, 8'h00);
    step(OST_N, 1'b1, 1'b0);
    step(1, 1'b0, 1'b1);
    rd(REG_OSC_CTRL);
    chk({7'h0, v[3]}, 8'h01);
    pulse(1'b1);
    rd(REG_OSC_CTRL);
    chk({7'h0, v[3]}, 8'h00);
    pulse(1'b0);
    chk({5'h0, src}, {5'h0, SRC_LOWFREQ});
    wr(REG_OSC_CTRL, 8'h70);
    for (int m = 0; m < 6; m++) begin
      do_reset(3'(m), 1'b1, 1'b1);
      chk({5'h0, src}, {5'h0, (m < 3) ? SRC_LOWFREQ : SRC_PRIMARY});
      rd(REG_OSC_CTRL);
      chk(v, (m < 3) ? 8'h00 : 8'h08);
    end
    do_reset(FOSC_EC, 1'b0, 1'b0);
    step(2 * SMP_N, 1'b0, 1'b1);
    chk({7'h0, flag}, 8'h00);
    do_reset(FOSC_EC, 1'b0, 1'b1);
    wd_en <= 1'b0;
    step(2 * SMP_N, 1'b0, 1'b1);
    chk({7'h0, flag}, 8'h01);
    chk(n_wdclr[7:0], 8'h02);
    do_reset(FOSC_EC, 1'b0, 1'b1);
    chk({5'h0, src}, {5'h0, SRC_PRIMARY});
    // With the power-up timer in use nothing starts until it expires.
    pwrt_n <= 1'b0;
    do_reset(FOSC_XT, 1'b1, 1'b0);
    chk({5'h0, src}, {5'h0, SRC_NONE});
    chk({7'h0, wd_hold}, 8'h00);
    pwr_done <= 1'b1;
    cyc(3);
    chk({5'h0, src}, {5'h0, SRC_LOWFREQ});
    wrap_up();
  end
endmodule : tb_two_speed_startup_fail_safe_clock
